// ==== rtl/deisr_regs.svh ====
// Register offsets, field positions, state codes and reset values of the event status block.
`ifndef DEISR_REGS_SVH
`define DEISR_REGS_SVH

// ****************************************************************
// Register offsets, byte addresses on the configuration port
// ****************************************************************
`define DEISR_OFS_MGR_STATUS 12'h000
`define DEISR_OFS_MGR_PC 12'h004
`define DEISR_OFS_SELECT 12'h020
`define DEISR_OFS_RAW 12'h024
`define DEISR_OFS_MASKED 12'h028
`define DEISR_OFS_CLEAR 12'h02c
`define DEISR_OFS_MGR_FAULT 12'h030
`define DEISR_OFS_CH_FAULT 12'h034

// ****************************************************************
// Field positions
// ****************************************************************
`define DEISR_NONSECURE_BIT 9
`define DEISR_WAKE_HI 8
`define DEISR_WAKE_LO 4
`define DEISR_STATE_HI 3
`define DEISR_STATE_LO 0
`define DEISR_MGR_FAULT_BIT 0

// ****************************************************************
// Manager operating state codes
// ****************************************************************
`define DEISR_ST_STOPPED 4'h0
`define DEISR_ST_EXECUTING 4'h1
`define DEISR_ST_CACHE_MISS 4'h2
`define DEISR_ST_UPDATING_PC 4'h3
`define DEISR_ST_WAIT_EVENT 4'h4
`define DEISR_ST_FAULTING 4'hf

// ****************************************************************
// Reset values
// ****************************************************************
`define DEISR_SELECT_RST 32'h0000_0000
`define DEISR_RDATA_RST 32'h0000_0000

`endif

// ==== rtl/deisr_pkg.sv ====
// Types shared by the event status block and its submodules.
package deisr_pkg;

    // Number of send-event resources.
    localparam int DEISR_NUM_RES = 32;

    // Configuration port request, one access.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } deisr_apb_req_t;

    // Configuration port response.
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } deisr_apb_rsp_t;

    // Manager thread view from the instruction engine.
    typedef struct packed {
        logic [3:0] op_state;
        logic [4:0] wait_event;
        logic [31:0] manager_pc_value;
    } deisr_mgr_info_t;

    // One send-event or wait-for-event instruction, valid for one cycle.
    typedef struct packed {
        logic valid;
        logic [4:0] num;
    } deisr_evt_t;

    // State of one event-interrupt resource.
    typedef struct packed {
        logic event_pend;
        logic irq;
    } deisr_res_state_t;

    // State of the top level.
    typedef struct packed {
        logic [31:0] select;
        logic sec_meta;
        logic sec_sync;
        logic [31:0] rdata;
    } deisr_top_state_t;

endpackage

// ==== rtl/deisr_event_bank.sv ====
// Per-resource event and interrupt flags with set and clear logic.
`timescale 1ns/1ps
`default_nettype none
`include "deisr_regs.svh"
module deisr_event_bank #(
    parameter int NUM_RES = 32 // Number of resources.
) (
    input wire logic core_clk, // Controller clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic ce, // Clock enable.
    input wire logic [NUM_RES-1:0] select, // One routes resource to its irq.
    input wire logic [NUM_RES-1:0] sev_hit, // Send-event pulse per resource.
    input wire logic [NUM_RES-1:0] wfe_hit, // Wait-for-event pulse per resource.
    input wire logic [NUM_RES-1:0] clr_hit, // Clear-register write ones.
    output logic [NUM_RES-1:0] irq, // Interrupt request lines.
    output logic [NUM_RES-1:0] event_pend, // Events offered to the threads.
    output logic [NUM_RES-1:0] raw, // Raw status.
    output logic [NUM_RES-1:0] masked // Masked status.
);
    import deisr_pkg::*;

    deisr_res_state_t [NUM_RES-1:0] st;
    deisr_res_state_t [NUM_RES-1:0] next_st;

    genvar i;
    generate
        for (i = 0; i < NUM_RES; i++) begin : g_res
            // Set wins over clear so that no event is lost.
            always_comb begin
                next_st[i] = st[i];
                if (wfe_hit[i] && !select[i]) begin
                    next_st[i].event_pend = 1'b0; // see [R10]
                end
                if (clr_hit[i] && select[i]) begin
                    next_st[i].irq = 1'b0; // see [R11] see [R14] see [R18]
                end
                if (sev_hit[i] && !select[i]) begin
                    next_st[i].event_pend = 1'b1; // see [R06]
                end
                if (sev_hit[i] && select[i]) begin
                    next_st[i].irq = 1'b1; // see [R07]
                end
            end

            // Status views of this resource.
            assign irq[i] = st[i].irq;
            assign event_pend[i] = st[i].event_pend;
            assign raw[i] = st[i].event_pend | st[i].irq; // see [R09]
            assign masked[i] = st[i].irq & select[i]; // see [R12] see [R13]

            a_sev_irq: assert property (@(posedge core_clk) disable iff (rst) // see [R07]
                (ce && sev_hit[i] && select[i]) |=> irq[i] && raw[i])
                else $error("irq not raised by send-event");
            a_sev_event: assert property (@(posedge core_clk) disable iff (rst) // see [R06]
                (ce && sev_hit[i] && !select[i]) |=> event_pend[i] && !masked[i])
                else $error("event not offered to threads");
            a_irq_hold: assert property (@(posedge core_clk) disable iff (rst) // see [R18]
                (irq[i] && !(ce && clr_hit[i] && select[i])) |=> irq[i])
                else $error("irq dropped without clear");
            a_clr_irq: assert property (@(posedge core_clk) disable iff (rst) // see [R14]
                (ce && clr_hit[i] && select[i] && !sev_hit[i]) |=> !irq[i])
                else $error("irq not cleared");
            a_wfe_clear: assert property (@(posedge core_clk) disable iff (rst) // see [R10]
                (ce && wfe_hit[i] && !select[i] && !sev_hit[i]) |=> !event_pend[i])
                else $error("event not consumed");
        end
    endgenerate

    // Flag registers, frozen while the clock enable is low.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end
endmodule // deisr_event_bank
`default_nettype wire

// ==== rtl/deisr_mgr_status.sv ====
// Packs the manager status and manager fault words.
`timescale 1ns/1ps
`default_nettype none
`include "deisr_regs.svh"
module deisr_mgr_status (
    input wire deisr_pkg::deisr_mgr_info_t mgr_info, // Manager view.
    input wire logic manager_nonsecure_flag, // Synchronised security level.
    output logic [31:0] status_word, // Manager status value.
    output logic [31:0] fault_word // Manager fault value.
);
    import deisr_pkg::*;

    logic manager_faulting_bit;

    // Wake-up event shows only while the manager waits for an event.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`DEISR_NONSECURE_BIT] = manager_nonsecure_flag; // see [R01] see [R02]
        if (mgr_info.op_state == `DEISR_ST_WAIT_EVENT) begin
            status_word[`DEISR_WAKE_HI:`DEISR_WAKE_LO] = mgr_info.wait_event; // see [R03]
        end
        status_word[`DEISR_STATE_HI:`DEISR_STATE_LO] = mgr_info.op_state; // see [R04]
    end

    // Fault bit follows the faulting state; upper bits read zero.
    assign manager_faulting_bit = (mgr_info.op_state == `DEISR_ST_FAULTING); // see [R15]
    assign fault_word = {31'h0000_0000, manager_faulting_bit};
endmodule // deisr_mgr_status
`default_nettype wire

// ==== rtl/deisr_top.sv ====
// Event, interrupt and manager status registers of the transfer controller.
// Behaviour
// [R01] Status bit 9 shows manager non-secure state.
// [R02] Manager security taken from boot security input.
// [R03] Status bits 8:4 show awaited event number.
// [R04] Status bits 3:0 encode manager operating state.
// [R05] Manager program counter readable as 32 bits.
// [R06] Select zero: send-event signals event to threads.
// [R07] Select one: send-event drives irq high.
// [R08] Software leaves unused irq selects at zero.
// [R09] Raw bit is event pending or irq.
// [R10] Event mode: wait-for-event clears raw bit.
// [R11] Interrupt mode: clear-register write clears raw bit.
// [R12] Masked bit equals active, high interrupt output.
// [R13] Masked bit reads zero in event mode.
// [R14] Clear write lowers irq only in interrupt mode.
// [R15] Manager fault bit 0 follows faulting state.
// [R16] Eight channel fault bits in 7:0.
// [R17] Select register read-write, steers later send-events.
// [R18] Irq stays high until qualifying clear.
`timescale 1ns/1ps
`default_nettype none
`include "deisr_regs.svh"
module deisr_top #(
    parameter int NUM_CH = 8 // Number of channels with fault flags.
) (
    input wire logic core_clk, // Controller clock, 20 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic ce, // Clock enable, freezes all state when low.
    input wire deisr_pkg::deisr_apb_req_t apb_req, // Configuration port request.
    output deisr_pkg::deisr_apb_rsp_t apb_rsp, // Configuration port response.
    input wire logic boot_security_select_input, // Pin, high selects non-secure.
    input wire deisr_pkg::deisr_mgr_info_t mgr_info, // Manager state from the engine.
    input wire deisr_pkg::deisr_evt_t send_event_instruction, // Send-event pulse.
    input wire deisr_pkg::deisr_evt_t wait_for_event_instruction, // Wait-for-event pulse.
    input wire logic [NUM_CH-1:0] ch_faulting, // Channel faulting or completing.
    output logic manager_nonsecure_flag, // Manager security state in use.
    output logic [deisr_pkg::DEISR_NUM_RES-1:0] event_pend, // Events to threads.
    output logic [deisr_pkg::DEISR_NUM_RES-1:0] irq // Interrupt request lines.
);
    import deisr_pkg::*;

    // ****************************************************************
    // State and decode signals
    // ****************************************************************
    deisr_top_state_t st;
    deisr_top_state_t next_st;

    logic setup_rd;
    logic access_wr;
    logic access_any;
    logic addr_hit;
    logic [DEISR_NUM_RES-1:0] sev_hit;
    logic [DEISR_NUM_RES-1:0] wfe_hit;
    logic [DEISR_NUM_RES-1:0] clr_hit;
    logic [DEISR_NUM_RES-1:0] raw;
    logic [DEISR_NUM_RES-1:0] masked;
    logic [31:0] status_word;
    logic [31:0] fault_word;
    logic [31:0] ch_fault_word;
    logic [31:0] read_mux;

    // ****************************************************************
    // Configuration port phases
    // ****************************************************************

    // Read data is fetched in the setup phase so that it stands in the access phase.
    assign setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

    // Writes act in the access phase, the only phase in which they complete.
    assign access_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign access_any = apb_req.psel && apb_req.penable;

    // Address decode for every mapped register.
    always_comb begin
        case (apb_req.paddr)
            `DEISR_OFS_MGR_STATUS: addr_hit = 1'b1;
            `DEISR_OFS_MGR_PC: addr_hit = 1'b1;
            `DEISR_OFS_SELECT: addr_hit = 1'b1;
            `DEISR_OFS_RAW: addr_hit = 1'b1;
            `DEISR_OFS_MASKED: addr_hit = 1'b1;
            `DEISR_OFS_CLEAR: addr_hit = 1'b1;
            `DEISR_OFS_MGR_FAULT: addr_hit = 1'b1;
            `DEISR_OFS_CH_FAULT: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // Every access completes at once; unmapped addresses answer with an error.
    assign apb_rsp = '{prdata: st.rdata, pready: 1'b1, pslverr: access_any && !addr_hit};

    // ****************************************************************
    // Instruction strobes to per-resource pulses
    // ****************************************************************

    // One-hot expansion of the resource number carried by each instruction.
    genvar n;
    generate
        for (n = 0; n < DEISR_NUM_RES; n++) begin : g_hit
            assign sev_hit[n] = send_event_instruction.valid
                && (send_event_instruction.num == 5'(n));
            assign wfe_hit[n] = wait_for_event_instruction.valid
                && (wait_for_event_instruction.num == 5'(n));
        end
    endgenerate

    // Clear write ones reach the resources only during a write access.
    assign clr_hit = (access_wr && apb_req.paddr == `DEISR_OFS_CLEAR) ?
        apb_req.pwdata : 32'h0000_0000; // see [R11] see [R14]

    // ****************************************************************
    // Submodules
    // ****************************************************************

    // Event and interrupt flags; the select register steers each send-event.
    deisr_event_bank #(
        .NUM_RES(DEISR_NUM_RES)
    ) u_bank (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .select(st.select), // see [R17]
        .sev_hit(sev_hit),
        .wfe_hit(wfe_hit),
        .clr_hit(clr_hit),
        .irq(irq),
        .event_pend(event_pend),
        .raw(raw),
        .masked(masked)
    );

    // Manager status and manager fault words.
    deisr_mgr_status u_mgr (
        .mgr_info(mgr_info),
        .manager_nonsecure_flag(st.sec_sync),
        .status_word(status_word),
        .fault_word(fault_word)
    );

    // The security state in use comes from the synchronised boot pin.
    assign manager_nonsecure_flag = st.sec_sync; // see [R02]

    // Channel fault flags sit in the low bits, the rest read zero.
    assign ch_fault_word = 32'(ch_faulting); // see [R16]

    // ****************************************************************
    // Read data selection
    // ****************************************************************

    // Write-only and unmapped registers read as zero.
    always_comb begin
        case (apb_req.paddr)
            `DEISR_OFS_MGR_STATUS: read_mux = status_word; // see [R01] see [R03] see [R04]
            `DEISR_OFS_MGR_PC: read_mux = mgr_info.manager_pc_value; // see [R05]
            `DEISR_OFS_SELECT: read_mux = st.select; // see [R17]
            `DEISR_OFS_RAW: read_mux = raw; // see [R09]
            `DEISR_OFS_MASKED: read_mux = masked; // see [R12] see [R13]
            `DEISR_OFS_MGR_FAULT: read_mux = fault_word; // see [R15]
            `DEISR_OFS_CH_FAULT: read_mux = ch_fault_word; // see [R16]
            default: read_mux = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Select writes, read capture and the two-stage pin synchroniser.
    always_comb begin
        next_st = st;
        next_st.sec_meta = boot_security_select_input;
        next_st.sec_sync = st.sec_meta; // see [R02]
        if (access_wr && apb_req.paddr == `DEISR_OFS_SELECT) begin
            next_st.select = apb_req.pwdata; // see [R17]
        end
        if (setup_rd) begin
            next_st.rdata = read_mux;
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st.select <= `DEISR_SELECT_RST;
            st.sec_meta <= 1'b0;
            st.sec_sync <= 1'b0;
            st.rdata <= `DEISR_RDATA_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    // A setup-phase read of a given register while the clock runs.
    sequence s_read_of(logic [11:0] ofs);
        ce && setup_rd && apb_req.paddr == ofs;
    endsequence

    // A write access to a given register while the clock runs.
    sequence s_write_of(logic [11:0] ofs);
        ce && access_wr && apb_req.paddr == ofs;
    endsequence

    a_read_raw: assert property (@(posedge core_clk) disable iff (rst) // see [R09]
        s_read_of(`DEISR_OFS_RAW) |=> apb_rsp.prdata == ($past(event_pend) | $past(irq)))
        else $error("raw status read mismatch");

    a_read_masked: assert property (@(posedge core_clk) disable iff (rst) // see [R12]
        s_read_of(`DEISR_OFS_MASKED) |=> apb_rsp.prdata == ($past(irq) & $past(st.select)))
        else $error("masked status read mismatch");

    a_masked_event: assert property (@(posedge core_clk) disable iff (rst) // see [R13]
        s_read_of(`DEISR_OFS_MASKED) |=> (apb_rsp.prdata & ~$past(st.select)) == 32'h0000_0000)
        else $error("masked bit set in event mode");

    a_dns_bit: assert property (@(posedge core_clk) disable iff (rst) // see [R01]
        s_read_of(`DEISR_OFS_MGR_STATUS)
        |=> apb_rsp.prdata[`DEISR_NONSECURE_BIT] == $past(manager_nonsecure_flag))
        else $error("security bit mismatch");

    a_boot_sync: assert property (@(posedge core_clk) disable iff (rst) // see [R02]
        (ce && $past(ce) && boot_security_select_input) ##1 ce |=> manager_nonsecure_flag)
        else $error("boot security level not taken");

    a_state_field: assert property (@(posedge core_clk) disable iff (rst) // see [R04]
        s_read_of(`DEISR_OFS_MGR_STATUS)
        |=> apb_rsp.prdata[`DEISR_STATE_HI:`DEISR_STATE_LO] == $past(mgr_info.op_state))
        else $error("manager state field mismatch");

    a_wake_field: assert property (@(posedge core_clk) disable iff (rst) // see [R03]
        s_read_of(`DEISR_OFS_MGR_STATUS) and mgr_info.op_state == `DEISR_ST_WAIT_EVENT
        |=> apb_rsp.prdata[`DEISR_WAKE_HI:`DEISR_WAKE_LO] == $past(mgr_info.wait_event))
        else $error("wake-up event field mismatch");

    a_pc_read: assert property (@(posedge core_clk) disable iff (rst) // see [R05]
        s_read_of(`DEISR_OFS_MGR_PC) |=> apb_rsp.prdata == $past(mgr_info.manager_pc_value))
        else $error("program counter read mismatch");

    a_mgr_fault: assert property (@(posedge core_clk) disable iff (rst) // see [R15]
        s_read_of(`DEISR_OFS_MGR_FAULT)
        |=> apb_rsp.prdata == {31'h0000_0000,
            $past(mgr_info.op_state) == `DEISR_ST_FAULTING})
        else $error("manager fault read mismatch");

    a_ch_fault: assert property (@(posedge core_clk) disable iff (rst) // see [R16]
        s_read_of(`DEISR_OFS_CH_FAULT) |=> apb_rsp.prdata == 32'($past(ch_faulting)))
        else $error("channel fault read mismatch");

    a_select_write: assert property (@(posedge core_clk) disable iff (rst) // see [R17]
        s_write_of(`DEISR_OFS_SELECT) |=> st.select == $past(apb_req.pwdata))
        else $error("select register not written");

    a_select_steer: assert property (@(posedge core_clk) disable iff (rst) // see [R07]
        s_write_of(`DEISR_OFS_SELECT) ##1 (ce && send_event_instruction.valid
            && st.select[send_event_instruction.num])
        |=> irq[$past(send_event_instruction.num)])
        else $error("send-event after select write not routed to irq");

endmodule // deisr_top
`default_nettype wire

// ==== tb/deisr_irq_sink.sv ====
// Interrupt receiver model that latches every request line it sees high.
`timescale 1ns/1ps
`default_nettype none
module deisr_irq_sink (
    input wire logic core_clk, // Controller clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic ack, // Reloads the latch with the live lines.
    input wire logic [31:0] irq, // Request lines from the block.
    output logic [31:0] seen // Requests seen since the last ack.
);
    // Level requests are latched, so a short high is never lost.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seen <= 32'h0;
        end else begin
            seen <= ack ? irq : (seen | irq);
        end
    end
endmodule // deisr_irq_sink
`default_nettype wire

// ==== tb/deisr_top_bench.sv ====
// Self-checking bench of the event, interrupt and manager status block.
`timescale 1ns/1ps
`default_nettype none
`include "deisr_regs.svh"
module deisr_top_bench;
    import deisr_pkg::*;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic core_clk, rst, ce, boot, ack, err, ns_flag;
    deisr_apb_req_t req;
    deisr_apb_rsp_t rsp;
    deisr_mgr_info_t mgr;
    deisr_evt_t sev, wfe;
    logic [7:0] chf;
    logic [31:0] pend, irq, seen, rd;
    int miscompares, checked, cycles;

    deisr_top i_deisr_top (.core_clk(core_clk), .rst(rst), .ce(ce), .apb_req(req),
        .apb_rsp(rsp), .boot_security_select_input(boot), .mgr_info(mgr),
        .send_event_instruction(sev), .wait_for_event_instruction(wfe), .ch_faulting(chf),
        .manager_nonsecure_flag(ns_flag), .event_pend(pend), .irq(irq));
    deisr_irq_sink i_deisr_irq_sink (.core_clk(core_clk), .rst(rst), .ack(ack), .irq(irq),
        .seen(seen));

    // Clock of 50 ns period.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Cuts a hang short after far more cycles than the tests need.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Compares one value and counts the result.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One setup and one access phase; the answer is taken at the access edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(negedge core_clk);
        req = '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(negedge core_clk);
        req.penable = 1'b1;
        @(posedge core_clk);
        rd = rsp.prdata;
        err = rsp.pslverr;
        @(negedge core_clk);
        req = '0;
    endtask

    // Reads a register and compares it.
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask

    // One-cycle send-event (s high) or wait-for-event pulse.
    task automatic fire(input logic s, input logic [4:0] n);
        @(negedge core_clk);
        if (s) sev = '{1'b1, n};
        else wfe = '{1'b1, n};
        @(negedge core_clk);
        sev.valid = 1'b0;
        wfe.valid = 1'b0;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Select register reset and read-back, then an unmapped read.
    task automatic t_select();
        rdchk(`DEISR_OFS_SELECT, 32'h0, "select reset");
        apb(1'b1, `DEISR_OFS_SELECT, 32'h8000_0001);
        rdchk(`DEISR_OFS_SELECT, 32'h8000_0001, "select");
        rdchk(12'h0fc, 32'h0, "unmapped data");
        check("unmapped err", 32'h1, 32'(err));
        check("ready", 32'h1, 32'(rsp.pready));
    endtask

    // Every manager state code with the security pin high, then the faulting code with it low.
    task automatic t_mgr();
        logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf};
        boot = 1'b1;
        repeat (3) @(negedge core_clk);
        check("ns flag", 32'h1, 32'(ns_flag));
        foreach (codes[i]) begin
            mgr = '{codes[i], 5'h15, 32'hc0de_0000 + i};
            rdchk(`DEISR_OFS_MGR_STATUS, {23'h1, codes[i] == 4'h4 ? 5'h15 : 5'h0, codes[i]},
                "status");
            rdchk(`DEISR_OFS_MGR_FAULT, {31'h0, codes[i] == 4'hf}, "mgr fault");
            rdchk(`DEISR_OFS_MGR_PC, 32'hc0de_0000 + i, "pc");
        end
        boot = 1'b0;
        repeat (3) @(negedge core_clk);
        rdchk(`DEISR_OFS_MGR_STATUS, 32'h0000_000f, "status secure");
    endtask

    // Channel fault flags follow the channel lines.
    task automatic t_chf();
        chf = 8'h81;
        rdchk(`DEISR_OFS_CH_FAULT, 32'h81, "ch fault");
        chf = 8'h7e;
        rdchk(`DEISR_OFS_CH_FAULT, 32'h7e, "ch fault");
    endtask

    // Resource 3 in event mode: a clear write is ignored, a wait clears it.
    task automatic t_event();
        fire(1'b1, 5'd3);
        check("pend", 32'h8, pend);
        check("irq", 32'h0, irq);
        rdchk(`DEISR_OFS_RAW, 32'h8, "raw");
        rdchk(`DEISR_OFS_MASKED, 32'h0, "masked");
        apb(1'b1, `DEISR_OFS_CLEAR, 32'h8);
        check("pend kept", 32'h8, pend);
        fire(1'b0, 5'd3);
        rdchk(`DEISR_OFS_RAW, 32'h0, "raw waited");
    endtask

    // Resource 31 in interrupt mode: only a one in bit 31 clears it.
    task automatic t_irq();
        fire(1'b1, 5'd31);
        check("irq", 32'h8000_0000, irq);
        rdchk(`DEISR_OFS_MASKED, 32'h8000_0000, "masked");
        check("sink", 32'h8000_0000, seen);
        fire(1'b0, 5'd31);
        apb(1'b1, `DEISR_OFS_CLEAR, 32'h7fff_ffff);
        check("irq kept", 32'h8000_0000, irq);
        apb(1'b1, `DEISR_OFS_CLEAR, 32'h8000_0000);
        check("irq cleared", 32'h0, irq);
        rdchk(`DEISR_OFS_RAW, 32'h0, "raw cleared");
        ack = 1'b1;
        @(negedge core_clk);
        ack = 1'b0;
        check("sink acked", 32'h0, seen);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    // Reset for six cycles, then the scenarios in turn.
    initial begin
        {rst, ce, boot, ack} = 4'b1100;
        {req, mgr, sev, wfe, chf} = '0;
        {miscompares, checked, cycles} = '0;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        t_select();
        t_mgr();
        t_chf();
        t_event();
        t_irq();
        finish_test();
    end
endmodule // deisr_top_bench
`default_nettype wire
